// file: mode_ctrl_defs.vh
// constants of the single-wire slave mode controller
// assumes a 40 MHz core clock and a 32-bit APB register port
`ifndef MODE_CTRL_DEFS_VH
`define MODE_CTRL_DEFS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS 25
// mode change time has no printed figure; plain default
`define MODE_CHG_NS 100000
`define MODE_CHG_CYC ((`MODE_CHG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// wake pulse on the bus is shorter than the txd low time by this much
`define TX_SHORT_NS 66000
`define TX_SHORT_CYC ((`TX_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// bus held low this long counts as a bus error
`define BUS_ERR_NS 2000000
`define BUS_ERR_CYC ((`BUS_ERR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// clock periods seen before the bus is released after undervoltage
`define UV_CLK_PERIODS 6'd33

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_THRESH 12'h004
`define REG_STATUS 12'h008
`define CTRL_WAKE_BIT 0
`define THRESH_RESET 16'h0190

// ----------------------------------------
// synchroniser bit positions
// ----------------------------------------
`define SY_SLEEP_REQUEST_LOW 0
`define SY_TXD 1
`define SY_ROLE 2
`define SY_BUS 3
`define SY_CLK 4
`define SY_OT 5
`define SY_UV 6
`define SY_W 7
// synchroniser reset levels: sleep requested, txd/role/bus/clock high, no fault
`define SY_RST 7'h1e

`endif

// file: mode_ctrl.v
// mode sequencing and protection of a single-wire bus slave transceiver
// assumes pins arrive asynchronously; the testbench resolves tri-state pins from the enables
//
// The address map and register access over APB were decided locally.
`include "mode_ctrl_defs.vh"

module mode_ctrl #(
    parameter [31:0] BUS_ERR_CYCLES = `BUS_ERR_CYC
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output reg pslverr_o,
    // controller side pins
    input wire sleep_request_low_i,
    input wire txd_i,
    input wire role_select_i,
    output reg rxd_o,
    output reg rxd_oe_o,
    input wire clk_pin_i,
    output reg clk_pin_o,
    output reg clk_pin_oe_o,
    // bus line, open drain: enable pulls low
    input wire bus_i,
    output reg bus_oe_o,
    // protection status
    input wire overtemp_i,
    input wire undervolt_i
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [6:0] S_SLEEP = 7'h01;
    localparam [6:0] S_STANDBY = 7'h02;
    localparam [6:0] S_NORMAL = 7'h04;
    localparam [6:0] S_WAKE = 7'h08;
    localparam [6:0] S_OT = 7'h10;
    localparam [6:0] S_WAKE_OT = 7'h20;
    localparam [6:0] S_UV = 7'h40;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    wire [`SY_W-1:0] raw_in;
    reg [`SY_W-1:0] meta_q;
    reg [`SY_W-1:0] sync_q;
    reg [`SY_W-1:0] prev_q;
    localparam [`SY_W-1:0] SYNC_RST = `SY_RST;
    assign raw_in = {undervolt_i, overtemp_i, clk_pin_i, bus_i, role_select_i, txd_i, sleep_request_low_i};

    genvar gi;
    generate
        for (gi = 0; gi < `SY_W; gi = gi + 1) begin : g_sync
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q[gi] <= SYNC_RST[gi];
                    sync_q[gi] <= SYNC_RST[gi];
                    prev_q[gi] <= SYNC_RST[gi];
                end else begin
                    meta_q[gi] <= raw_in[gi];
                    sync_q[gi] <= meta_q[gi];
                    prev_q[gi] <= sync_q[gi];
                end
            end
        end
    endgenerate

    wire sleep_request_low = sync_q[`SY_SLEEP_REQUEST_LOW];
    wire txd = sync_q[`SY_TXD];
    wire slave = sync_q[`SY_ROLE];
    wire bus = sync_q[`SY_BUS];
    wire ot = sync_q[`SY_OT];
    wire uv = sync_q[`SY_UV];
    wire sleep_request_low_fall = prev_q[`SY_SLEEP_REQUEST_LOW] & ~sleep_request_low;
    wire sleep_request_low_rise = ~prev_q[`SY_SLEEP_REQUEST_LOW] & sleep_request_low;
    wire txd_fall = prev_q[`SY_TXD] & ~txd;
    wire bus_rise = ~prev_q[`SY_BUS] & bus;
    // master counts its clock input, slave the rising edges it sees on the bus
    wire clk_rise = slave ? bus_rise : (~prev_q[`SY_CLK] & sync_q[`SY_CLK]);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [6:0] state_q, state_d;
    reg [12:0] mode_cnt_q;
    reg [12:0] short_cnt_q;
    reg [31:0] low_cnt_q;
    reg [15:0] thresh_q;
    reg wake_req_q;
    reg tx_armed_q;
    reg uv_pend_q;
    reg [5:0] uv_clk_q;
    reg bus_err_q;
    reg rx_bit_q;

    wire bus_err_now = (low_cnt_q >= BUS_ERR_CYCLES);
    wire uv_clk_done = (uv_clk_q >= `UV_CLK_PERIODS);
    wire mode_done = (mode_cnt_q >= `MODE_CHG_CYC);

    // ----------------------------------------
    // mode state machine
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            S_SLEEP: begin
                if (sleep_request_low_rise || wake_req_q)
                    state_d = S_STANDBY;
                else if (slave && !sleep_request_low && !txd && tx_armed_q)
                    state_d = S_WAKE;
            end
            S_STANDBY: begin
                if (!sleep_request_low || bus_err_now)
                    state_d = S_SLEEP;
                else if (mode_done)
                    state_d = S_NORMAL;
            end
            S_NORMAL: begin
                if (sleep_request_low_fall || !sleep_request_low || bus_err_now)
                    state_d = S_SLEEP;
                else if (ot)
                    state_d = S_OT;
            end
            S_WAKE: begin
                if (ot)
                    state_d = S_WAKE_OT;
                else if (sleep_request_low)
                    state_d = S_STANDBY;
                else if (txd)
                    state_d = S_SLEEP;
            end
            S_OT: begin
                if (!sleep_request_low)
                    state_d = S_SLEEP;
                else if (!ot)
                    state_d = S_NORMAL;
            end
            S_WAKE_OT: begin
                if (sleep_request_low)
                    state_d = S_STANDBY;
                else if (!ot)
                    state_d = S_SLEEP;
            end
            S_UV: begin
                state_d = sleep_request_low ? S_STANDBY : S_SLEEP;
            end
            default: state_d = S_SLEEP;
        endcase
        if (uv)
            state_d = S_UV;
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= S_SLEEP;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // timers and transmit gating
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_cnt_q <= 13'h0000;
            short_cnt_q <= 13'h0000;
            low_cnt_q <= 32'h00000000;
            tx_armed_q <= 1'b0;
            uv_pend_q <= 1'b0;
            uv_clk_q <= 6'h00;
            bus_err_q <= 1'b0;
        end else begin
            mode_cnt_q <= (state_q == S_STANDBY && !mode_done) ? mode_cnt_q + 13'h0001 : 13'h0000;
            // counts txd low time so the bus pulse starts late by the shortening time
            if (state_q == S_WAKE && !txd && short_cnt_q < `TX_SHORT_CYC)
                short_cnt_q <= short_cnt_q + 13'h0001;
            else if (txd)
                short_cnt_q <= 13'h0000;
            // only meaningful while we are not pulling the bus ourselves
            if (bus || bus_oe_o || (state_q & (S_SLEEP | S_UV)) != 7'h00)
                low_cnt_q <= 32'h00000000;
            else if (!bus_err_now)
                low_cnt_q <= low_cnt_q + 32'h00000001;
            if (bus_err_now)
                bus_err_q <= 1'b1;
            else if (psel_i && penable_i && pwrite_i && paddr_i == `REG_STATUS)
                bus_err_q <= 1'b0;
            // a stuck-low txd arms the driver only right after reset, from the high txd synchroniser reset level
            if (state_d != state_q && (state_d & (S_NORMAL | S_SLEEP | S_UV)) != 7'h00)
                tx_armed_q <= 1'b0;
            else if (txd)
                tx_armed_q <= 1'b1;
            if (state_q == S_UV) begin
                uv_pend_q <= 1'b1;
                uv_clk_q <= 6'h00;
            end else begin
                if (txd_fall)
                    uv_pend_q <= 1'b0;
                if (clk_rise && !uv_clk_done)
                    uv_clk_q <= uv_clk_q + 6'h01;
            end
        end
    end

    // ----------------------------------------
    // receive decode and pin drive
    // ----------------------------------------
    // long low phase is a logical zero, short one a logical one
    reg [15:0] bit_low_q;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_low_q <= 16'h0000;
            rx_bit_q <= 1'b1;
        end else begin
            if (bus)
                bit_low_q <= 16'h0000;
            else if (bit_low_q != 16'hffff)
                bit_low_q <= bit_low_q + 16'h0001;
            if (bus_rise)
                rx_bit_q <= (bit_low_q < thresh_q);
        end
    end

    wire normal_tx = (state_q == S_NORMAL) && tx_armed_q && !uv_pend_q && uv_clk_done;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_oe_o <= 1'b0;
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
            clk_pin_o <= 1'b1;
            clk_pin_oe_o <= 1'b0;
        end else begin
            bus_oe_o <= 1'b0;
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
            clk_pin_o <= 1'b1;
            clk_pin_oe_o <= 1'b0;
            case (state_q)
                S_SLEEP: begin
                    rxd_oe_o <= 1'b1;
                    clk_pin_oe_o <= slave;
                    clk_pin_o <= bus;
                end
                S_WAKE: begin
                    bus_oe_o <= sleep_request_low_fall ? 1'b0 : (!txd && short_cnt_q >= `TX_SHORT_CYC);
                    rxd_oe_o <= 1'b1;
                    clk_pin_oe_o <= 1'b1;
                    clk_pin_o <= bus;
                end
                S_NORMAL, S_OT: begin
                    rxd_oe_o <= 1'b1;
                    rxd_o <= rx_bit_q;
                    clk_pin_oe_o <= slave;
                    clk_pin_o <= bus;
                    // master drives the clock low phase, both roles stretch it for zeros
                    if (state_q == S_NORMAL && normal_tx && !sleep_request_low_fall)
                        bus_oe_o <= slave ? (!bus && !txd) : (!sync_q[`SY_CLK] || !txd);
                end
                S_WAKE_OT: begin
                    rxd_oe_o <= 1'b1;
                    clk_pin_oe_o <= 1'b1;
                    clk_pin_o <= bus;
                end
                default: begin
                    bus_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------
    assign pready_o = 1'b1;
    wire acc = psel_i && penable_i;
    wire mapped = (paddr_i == `REG_CTRL) || (paddr_i == `REG_THRESH) || (paddr_i == `REG_STATUS);
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thresh_q <= `THRESH_RESET;
            wake_req_q <= 1'b0;
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= psel_i && !penable_i && !mapped;
            wake_req_q <= 1'b0;
            if (acc && pwrite_i && paddr_i == `REG_CTRL)
                wake_req_q <= pwdata_i[`CTRL_WAKE_BIT];
            if (acc && pwrite_i && paddr_i == `REG_THRESH)
                thresh_q <= pwdata_i[15:0];
            prdata_o <= 32'h00000000;
            if (psel_i && !penable_i && !pwrite_i) begin
                case (paddr_i)
                    `REG_THRESH: prdata_o <= {16'h0000, thresh_q};
                    `REG_STATUS: prdata_o <= {20'h00000, bus_err_q, uv_pend_q, tx_armed_q, uv_clk_done, 1'b0, state_q};
                    default: prdata_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // mode_ctrl

// file: mode_ctrl_assertions.sv
// concurrent checks on the ports of the mode controller
// assumes one clk_i domain; bound onto every mode_ctrl below
`include "mode_ctrl_defs.vh"
module mode_ctrl_assertions (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // apb
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    // pins
    input wire sleep_request_low_i,
    input wire txd_i,
    input wire role_select_i,
    input wire rxd_o,
    input wire rxd_oe_o,
    input wire clk_pin_i,
    input wire clk_pin_o,
    input wire clk_pin_oe_o,
    input wire bus_i,
    input wire bus_oe_o,
    input wire overtemp_i,
    input wire undervolt_i
);
    localparam int SHORT = `TX_SHORT_CYC;
    logic [15:0] low_q;
    wire mapped = paddr_i == `REG_CTRL || paddr_i == `REG_THRESH || paddr_i == `REG_STATUS;
    // saturating run of txd low, to bound the wake pulse start
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) low_q <= 16'h0000;
        else if (txd_i) low_q <= 16'h0000;
        else if (low_q != 16'hffff) low_q <= low_q + 16'h0001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_bus_low; (!bus_i) [*6]; endsequence
    sequence s_bus_high; bus_i [*6]; endsequence
    a_unmapped_err: assert property (psel_i && penable_i && !mapped |-> pslverr_o)
        else $error("unmapped access without pslverr");
    a_apb_idle_zero: assert property (!(psel_i && penable_i) |-> !pslverr_o && prdata_o == 32'h0)
        else $error("apb outputs not zero outside access");
    a_clk_low_bus: assert property (s_bus_low ##0 clk_pin_oe_o |-> !clk_pin_o)
        else $error("clock pin high while bus low");
    a_clk_high_bus: assert property (s_bus_high ##0 clk_pin_oe_o |-> clk_pin_o)
        else $error("clock pin low while bus high");
    a_sleep_rxd_high: assert property ((!sleep_request_low_i) [*6] |-> rxd_o || !rxd_oe_o)
        else $error("receive pin low in sleep");
    a_sleep_tx_off: assert property ($fell(sleep_request_low_i) |-> ##5 !bus_oe_o)
        else $error("bus driven after sleep request");
    a_wake_short: assert property ($rose(bus_oe_o) && !sleep_request_low_i |-> low_q >= SHORT)
        else $error("wake pulse not shortened");
    a_wake_release: assert property (txd_i [*5] ##0 !sleep_request_low_i |-> !bus_oe_o)
        else $error("bus held after txd high in sleep");
    a_uv_hiz: assert property (undervolt_i [*5] |-> !(bus_oe_o || rxd_oe_o || clk_pin_oe_o))
        else $error("pin driven in undervoltage");
    a_ot_bus_off: assert property (overtemp_i [*5] |-> !bus_oe_o)
        else $error("bus driven in overtemperature");
endmodule // mode_ctrl_assertions

bind mode_ctrl mode_ctrl_assertions mode_ctrl_assertions_i (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sleep_request_low_i, .txd_i, .role_select_i,
    .rxd_o, .rxd_oe_o, .clk_pin_i, .clk_pin_o, .clk_pin_oe_o, .bus_i, .bus_oe_o, .overtemp_i, .undervolt_i);

// file: ctrl_model.sv
// controller model driving sleep request, transmit and role pins
// assumes the bench calls its tasks; pins move just after clk_i edges
module ctrl_model (
    // clock
    input wire clk_i,
    // pins towards the transceiver
    output logic sleep_request_low_o,
    output logic txd_o,
    output logic role_select_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sleep_request_low_o = 1'b0;
        txd_o = 1'b1;
        role_select_o = 1'b1;
    end
    // sleep request only moves with txd already high
    task set_sleep_request_low(input logic v);
        @(posedge clk_i);
        txd_o <= 1'b1;
        @(posedge clk_i);
        sleep_request_low_o <= v;
    endtask
    // role only changes while asleep
    task set_role(input logic v);
        @(posedge clk_i);
        role_select_o <= v;
    endtask
    // low while asleep in the slave role makes the wake pulse; after undervoltage a toggle
    task set_txd(input logic v);
        @(posedge clk_i);
        txd_o <= v;
    endtask
endmodule // ctrl_model

// file: test_mode_ctrl.sv
// self-checking bench for the mode controller
// assumes mode_ctrl, its checker and ctrl_model are compiled first
`include "mode_ctrl_defs.vh"
module test_mode_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i;
    logic rst_n_i;
    logic psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic overtemp_i, undervolt_i, ext_low, mclk;
    logic [31:0] rdat;
    logic err;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, rxd_o, rxd_oe_o, clk_pin_o, clk_pin_oe_o, bus_oe_o, sleep_request_low, txd, role;
    // open-drain bus with pull-up; released clock pin carries the bench's master baud clock
    wire bus_i = !(bus_oe_o || ext_low);
    wire clk_pin_i = clk_pin_oe_o ? clk_pin_o : mclk;
    int n_mismatch = 0, checks_done = 0, cyc = 0, oe_cyc = 0, low_cyc = 0;
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = !clk_i;
    end
    mode_ctrl #(.BUS_ERR_CYCLES(32'd200)) mode_ctrl_i (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sleep_request_low_i(sleep_request_low), .txd_i(txd),
        .role_select_i(role), .rxd_o, .rxd_oe_o, .clk_pin_i, .clk_pin_o, .clk_pin_oe_o, .bus_i, .bus_oe_o,
        .overtemp_i, .undervolt_i);
    ctrl_model ctrl_model_i (.clk_i, .sleep_request_low_o(sleep_request_low), .txd_o(txd), .role_select_o(role));
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (bus_oe_o === 1'b1) oe_cyc <= oe_cyc + 1;
        if (txd === 1'b0) low_cyc <= low_cyc + 1;
        if (cyc == 60000) begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end
    task stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // request held until pready is seen high at an edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // ends at the first edge that sees pready_o high
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rdat = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rdat & m, e);
    endtask
    task st(input logic [31:0] e, input int wait_n);
        tick(wait_n);
        rd(`REG_STATUS, 32'h7f, e);
    endtask
    initial begin
        int a0;
        int l0;
        int d;
        rst_n_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        overtemp_i = 1'b0;
        undervolt_i = 1'b0;
        ext_low = 1'b0;
        mclk = 1'b1;
        tick(2);
        rst_n_i <= 1'b1;
        st(32'h01, 1);
        rd(`REG_THRESH, 32'hffff, {16'h0, `THRESH_RESET});
        apb(1'b1, `REG_THRESH, 32'h0155);
        rd(`REG_THRESH, 32'hffff, 32'h0155);
        apb(1'b1, 12'h00c, 32'h1);
        check("pslverr", {31'h0, err}, 32'h1);
        check("sleep pins", {rxd_o, rxd_oe_o, bus_oe_o}, 3'b110);
        $display("test reset done");
        overtemp_i <= 1'b1;
        ext_low <= 1'b1;
        tick(20);
        check("clk pin", {clk_pin_oe_o, clk_pin_o, rxd_o}, 3'b101);
        st(32'h01, 0);
        overtemp_i <= 1'b0;
        ext_low <= 1'b0;
        $display("test sleep done");
        a0 = oe_cyc;
        l0 = low_cyc;
        ctrl_model_i.set_txd(1'b0);
        st(32'h08, 100);
        tick(18614);
        ctrl_model_i.set_txd(1'b1);
        st(32'h01, 10);
        d = oe_cyc - a0 - (low_cyc - l0) + `TX_SHORT_CYC;
        check("pulse width", d >= -6 && d <= 6, 32'h1);
        ctrl_model_i.set_txd(1'b0);
        tick(2700);
        check("wake drive", {31'h0, bus_oe_o}, 32'h1);
        overtemp_i <= 1'b1;
        st(32'h20, 8);
        check("ot bus", {31'h0, bus_oe_o}, 32'h0);
        ctrl_model_i.set_txd(1'b1);
        overtemp_i <= 1'b0;
        st(32'h01, 8);
        $display("test wake done");
        ctrl_model_i.set_sleep_request_low(1'b1);
        st(32'h02, 8);
        check("standby hiz", {rxd_oe_o, clk_pin_oe_o, bus_oe_o}, 3'b000);
        st(32'h04, `MODE_CHG_CYC);
        check("slave clk", {31'h0, clk_pin_oe_o}, 32'h1);
        overtemp_i <= 1'b1;
        st(32'h10, 8);
        overtemp_i <= 1'b0;
        st(32'h04, 8);
        ctrl_model_i.set_sleep_request_low(1'b0);
        st(32'h01, 8);
        $display("test normal done");
        undervolt_i <= 1'b1;
        st(32'h40, 8);
        ctrl_model_i.set_sleep_request_low(1'b1);
        undervolt_i <= 1'b0;
        st(32'h02, 8);
        tick(`MODE_CHG_CYC);
        rd(`REG_STATUS, 32'h0500, 32'h0400);
        ctrl_model_i.set_txd(1'b0);
        ctrl_model_i.set_txd(1'b1);
        // another node clocks the bus at 200 ns
        repeat (34) begin
            ext_low <= 1'b1;
            tick(4);
            ext_low <= 1'b0;
            tick(4);
        end
        rd(`REG_STATUS, 32'h077f, 32'h0304);
        ext_low <= 1'b1;
        tick(220);
        ext_low <= 1'b0;
        tick(8);
        rd(`REG_STATUS, 32'h087f, 32'h0801);
        apb(1'b1, `REG_STATUS, 32'h0);
        rd(`REG_STATUS, 32'h0800, 32'h0);
        $display("test undervoltage done");
        ctrl_model_i.set_role(1'b0);
        apb(1'b1, `REG_CTRL, 32'h1);
        st(32'h02, 8);
        st(32'h04, `MODE_CHG_CYC);
        check("master clk", {31'h0, clk_pin_oe_o}, 32'h0);
        mclk <= 1'b0;
        tick(6);
        check("master drive", {31'h0, bus_oe_o}, 32'h1);
        mclk <= 1'b1;
        tick(6);
        check("master idle", {31'h0, bus_oe_o}, 32'h0);
        $display("test wake request done");
        stop_test();
    end
endmodule // test_mode_ctrl
